// ==== hdl/srp_pkg.sv ====
package srp_pkg;

    // command opcodes
    localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] OP_SECREG_PROG  = 8'h42;
    localparam logic [7:0] OP_SECREG_READ  = 8'h48;

    // address layout
    localparam logic [7:0] ADDR_TOP_VALUE  = 8'h00;
    localparam logic [7:0] SECREG_LAST     = 8'h03;
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;
    localparam int         REG_BYTES       = 256;
    localparam int         MEM_BYTES       = 1024;

    // rising-edge counts within a frame
    localparam logic [5:0] BC_FIRST        = 6'h00;
    localparam logic [5:0] BC_OP_END       = 6'h07;
    localparam logic [5:0] BC_ADDR_FIRST   = 6'h08;
    localparam logic [5:0] BC_ADDR_END     = 6'h1F;
    localparam logic [5:0] BC_BYTE1_END    = 6'h27;
    localparam logic [5:0] BC_DATA_FIRST   = 6'h28;
    localparam logic [5:0] BC_DATA_END     = 6'h2F;

    // programming cycle timing
    localparam int         CLK_MHZ         = 125;
    localparam int         PROG_TIME_NS    = 2400000;
    localparam int         PROG_CYCLES     = (PROG_TIME_NS * CLK_MHZ) / 1000;
    localparam logic [3:0] SETTLE_CYCLES   = 4'h8;

    typedef enum logic [1:0] {
        SRP_IDLE,
        SRP_SETTLE,
        SRP_WALK,
        SRP_HOLD
    } srp_state_t;

endpackage : srp_pkg

// ==== hdl/srp_secreg.sv ====
`timescale 1ns/1ps

// Overview of operation
// - A program frame is chip select low, opcode 42H, three address bytes and at least one data byte.
// - One to 256 data bytes are accepted per program frame and every received byte is programmed.
// - The rising chip select ending a valid program frame starts a self-timed page-program-length cycle.
// - The cycle-active flag reads 1 throughout the programming cycle and 0 once it is done.
// - The write latch flag is cleared before the programming cycle completes.
// - With the lock bit at 1 every program command is ignored and the registers stay unchanged.
// - Program address: top byte 00H, middle byte picks register 00H to 03H, low byte is the byte offset.
// - A read frame is opcode 48H, three address bytes and one dummy byte, all sampled on rising serial clock.
// - After the dummy byte read data is driven MSB first, changing on the falling serial clock edge.
// - Reads may start anywhere and the read address advances by one after each byte.
// - When the ten low address bits pass 3FFH reading wraps to 000H and runs until chip select rises.
// - Memory starts at FFH in every byte and all status flags start at 0.
// - The write-permit command is opcode 06H sent alone in its own frame and sets the write latch flag if its frame ends while no programming cycle is active.
// - The lock bit is one-time settable and once set blocks program until rst_n clears it.
module srp_secreg #(
    parameter int unsigned PROG_CYCLES = srp_pkg::PROG_CYCLES
) (
    // system
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // serial link
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic si,
    output logic      so,
    output logic      so_oe,
    // status
    input  wire logic secreg_lock_set,
    output logic      secreg_lock_bit,
    output logic      write_latch_flag,
    output logic      cycle_active_flag
);

    // ---------------- link domain (sclk) ----------------
    logic        link_rst_n;
    logic [5:0]  bcnt;
    logic [6:0]  shin;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic        permit_ok;
    logic        prog_ok;
    logic [7:0]  pb_data;
    logic [7:0]  pb_off;
    logic        pb_tog;
    logic [9:0]  rd_addr;
    logic        rd_req;
    logic        ack_s1;
    logic        ack_s2;
    logic [7:0]  out_byte;
    logic [7:0]  in_byte;
    logic        byte_end;
    logic        rd_ack;
    logic [7:0]  rd_data;

    // chip select high ends a frame at once, with or without a clock edge
    assign link_rst_n = rst_n & ~cs_n;
    assign in_byte    = {shin, si};
    assign byte_end   = (bcnt == srp_pkg::BC_BYTE1_END) || (bcnt == srp_pkg::BC_DATA_END);

    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bcnt <= srp_pkg::BC_FIRST;
        end else if (bcnt == srp_pkg::BC_DATA_END) begin
            bcnt <= srp_pkg::BC_DATA_FIRST;
        end else begin
            bcnt <= bcnt + 6'h01;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shin   <= 7'h00;
            opcode <= 8'h00;
            addr   <= 24'h000000;
        end else begin
            shin <= in_byte[6:0];
            if (bcnt == srp_pkg::BC_OP_END) begin
                opcode <= in_byte;
            end
            if (bcnt >= srp_pkg::BC_ADDR_FIRST && bcnt <= srp_pkg::BC_ADDR_END) begin
                addr <= {addr[22:0], si};
            end
        end
    end

    // frame verdicts stay put after chip select rises, since sclk is idle then
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            permit_ok <= 1'b0;
            prog_ok   <= 1'b0;
        end else if (bcnt == srp_pkg::BC_FIRST) begin
            permit_ok <= 1'b0;
            prog_ok   <= 1'b0;
        end else if (bcnt == srp_pkg::BC_OP_END) begin
            permit_ok <= (in_byte == srp_pkg::OP_WRITE_PERMIT);
        end else if (bcnt == srp_pkg::BC_ADDR_FIRST) begin
            permit_ok <= 1'b0;
        end else if (bcnt == srp_pkg::BC_BYTE1_END) begin
            prog_ok <= (opcode == srp_pkg::OP_SECREG_PROG) && (addr[23:16] == srp_pkg::ADDR_TOP_VALUE)
                       && (addr[15:8] <= srp_pkg::SECREG_LAST);
        end
    end

    // each program byte is handed over by a toggle; offset wraps within one register
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            pb_data <= 8'h00;
            pb_off  <= 8'h00;
            pb_tog  <= 1'b0;
        end else if (byte_end && opcode == srp_pkg::OP_SECREG_PROG) begin
            pb_data <= in_byte;
            pb_off  <= (bcnt == srp_pkg::BC_BYTE1_END) ? addr[7:0] : pb_off + 8'h01;
            pb_tog  <= ~pb_tog;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= rd_ack;
            ack_s2 <= ack_s1;
        end
    end

    // fetch of the next byte is requested a whole byte time before it is needed
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_addr  <= 10'h000;
            rd_req   <= 1'b0;
            out_byte <= srp_pkg::ERASED_BYTE;
        end else if (opcode == srp_pkg::OP_SECREG_READ && bcnt == srp_pkg::BC_ADDR_END) begin
            rd_addr <= {addr[8:0], si};
            rd_req  <= ~rd_req;
        end else if (opcode == srp_pkg::OP_SECREG_READ && byte_end) begin
            // a fetch still in flight (serial clock far above spec) returns the erased value
            out_byte <= (ack_s2 == rd_req) ? rd_data : srp_pkg::ERASED_BYTE;
            rd_addr  <= rd_addr + 10'h001;
            rd_req   <= ~rd_req;
        end
    end

    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            so    <= 1'b0;
            so_oe <= 1'b0;
        end else if (opcode == srp_pkg::OP_SECREG_READ && bcnt >= srp_pkg::BC_DATA_FIRST) begin
            so    <= out_byte[~bcnt[2:0]];
            so_oe <= 1'b1;
        end
    end

    // ---------------- core domain (ref_clk) ----------------
    // cells hold their cleared bits, so the array starts out erased without an initial block
    bit   [7:0]  cleared [0:srp_pkg::MEM_BYTES-1];
    logic [7:0]  stage [0:srp_pkg::REG_BYTES-1];
    logic [255:0] mask;
    logic [15:0] fifo [0:1];
    logic [1:0]  wp;
    logic [1:0]  rp;
    logic        fifo_full;
    logic        fifo_empty;
    logic        push;
    logic        pop;
    logic        pending;
    logic        cs_s1, cs_s2, cs_s3;
    logic        pb_s1, pb_s2, pb_s3;
    logic        rd_s1, rd_s2;
    logic        frame_end;
    logic        frame_start;
    logic        go;
    logic [1:0]  sel;
    logic [7:0]  ptr;
    logic [3:0]  settle;
    logic [31:0] timer;
    srp_pkg::srp_state_t state;
    srp_pkg::srp_state_t next_state;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            pb_s1 <= 1'b0;
            pb_s2 <= 1'b0;
            pb_s3 <= 1'b0;
            rd_s1 <= 1'b0;
            rd_s2 <= 1'b0;
        end else begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            pb_s1 <= pb_tog;
            pb_s2 <= pb_s1;
            pb_s3 <= pb_s2;
            rd_s1 <= rd_req;
            rd_s2 <= rd_s1;
        end
    end

    assign frame_end   = cs_s2 & ~cs_s3;
    assign frame_start = ~cs_s2 & cs_s3;

    // two-entry buffer between the link and the staging page
    assign fifo_full  = (wp[1] != rp[1]) && (wp[0] == rp[0]);
    assign fifo_empty = (wp == rp);
    assign push       = pending && !fifo_full;
    assign pop        = !fifo_empty && (state != srp_pkg::SRP_WALK);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (pb_s2 != pb_s3) begin
            pending <= 1'b1;
        end else if (push) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= 2'h0;
            rp <= 2'h0;
        end else begin
            if (push) begin
                wp <= wp + 2'h1;
            end
            if (pop) begin
                rp <= rp + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            fifo[wp[0]] <= {pb_off, pb_data};
        end
        if (pop) begin
            stage[fifo[rp[0]][15:8]] <= fifo[rp[0]][7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= '0;
        end else if (frame_start && state == srp_pkg::SRP_IDLE) begin
            mask <= '0;
        end else if (pop) begin
            mask[fifo[rp[0]][15:8]] <= 1'b1;
        end
    end

    // read port: answers each toggle request with the byte at the link's address
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= srp_pkg::ERASED_BYTE;
            rd_ack  <= 1'b0;
        end else if (rd_s2 != rd_ack) begin
            rd_data <= ~cleared[rd_addr];
            rd_ack  <= rd_s2;
        end
    end

    // settle lets the last byte of the frame cross before the walk stalls the buffer
    assign go = frame_end && prog_ok && write_latch_flag && !secreg_lock_bit
                && (state == srp_pkg::SRP_IDLE);

    always_comb begin
        next_state = state;
        case (state)
            srp_pkg::SRP_IDLE:   if (go) next_state = srp_pkg::SRP_SETTLE;
            srp_pkg::SRP_SETTLE: if (settle == srp_pkg::SETTLE_CYCLES) next_state = srp_pkg::SRP_WALK;
            srp_pkg::SRP_WALK:   if (ptr == 8'hFF) next_state = srp_pkg::SRP_HOLD;
            srp_pkg::SRP_HOLD:   if (timer >= PROG_CYCLES - 1) next_state = srp_pkg::SRP_IDLE;
            default:             next_state = srp_pkg::SRP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state             <= srp_pkg::SRP_IDLE;
            cycle_active_flag <= 1'b0;
        end else begin
            state             <= next_state;
            cycle_active_flag <= (next_state != srp_pkg::SRP_IDLE);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel    <= 2'h0;
            ptr    <= 8'h00;
            settle <= 4'h0;
            timer  <= 32'h0;
        end else if (state == srp_pkg::SRP_IDLE) begin
            sel    <= addr[9:8];
            ptr    <= 8'h00;
            settle <= 4'h0;
            timer  <= 32'h0;
        end else begin
            timer <= timer + 32'h1;
            if (state == srp_pkg::SRP_SETTLE) begin
                settle <= settle + 4'h1;
            end
            if (state == srp_pkg::SRP_WALK) begin
                ptr <= ptr + 8'h01;
            end
        end
    end

    // flash cells only move from 1 to 0
    always_ff @(posedge ref_clk) begin
        if (state == srp_pkg::SRP_WALK && mask[ptr]) begin
            cleared[{sel, ptr}] <= cleared[{sel, ptr}] | ~stage[ptr];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_latch_flag <= 1'b0;
        end else if (state == srp_pkg::SRP_WALK && ptr == 8'hFF) begin
            write_latch_flag <= 1'b0;
        end else if (frame_end && permit_ok && state == srp_pkg::SRP_IDLE) begin
            write_latch_flag <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            secreg_lock_bit <= 1'b0;
        end else if (secreg_lock_set) begin
            secreg_lock_bit <= 1'b1;
        end
    end

endmodule : srp_secreg

// ==== sim/srp_secreg_checker.sv ====
`timescale 1ns/1ps
module srp_secreg_checker #(
    parameter int unsigned PROG_CYCLES = 400
) (
    // system
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    // status
    input wire logic secreg_lock_set,
    input wire logic secreg_lock_bit,
    input wire logic write_latch_flag,
    input wire logic cycle_active_flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    int unsigned busy_cnt;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) busy_cnt <= 0;
        else busy_cnt <= cycle_active_flag ? busy_cnt + 1 : 0;
    end
    oe_idle_a: assert property (cs_n && $past(cs_n) |-> !so_oe)
        else $error("so_oe high while deselected");
    prog_start_a: assert property ($rose(cycle_active_flag) |-> cs_n && !$past(cs_n, 6))
        else $error("cycle not started by frame end");
    prog_gate_a: assert property ($rose(cycle_active_flag) |-> $past(write_latch_flag) && !$past(secreg_lock_bit))
        else $error("cycle started while locked or latch clear");
    busy_len_a: assert property ($fell(cycle_active_flag) |-> busy_cnt + 2 >= PROG_CYCLES && busy_cnt <= PROG_CYCLES + 2)
        else $error("cycle length wrong");
    busy_max_a: assert property (busy_cnt <= PROG_CYCLES + 2)
        else $error("cycle overran");
    latch_clear_a: assert property ($fell(cycle_active_flag) |-> !write_latch_flag)
        else $error("latch still set at cycle end");
    latch_set_a: assert property ($rose(write_latch_flag) |-> cs_n && !cycle_active_flag)
        else $error("latch set outside idle frame end");
    lock_set_a: assert property (secreg_lock_set |-> ##[1:3] secreg_lock_bit)
        else $error("lock bit not set");
    lock_hold_a: assert property (secreg_lock_bit |=> secreg_lock_bit)
        else $error("lock bit dropped");
    cover property ($rose(cycle_active_flag));
    cover property ($rose(so_oe));
    cover property ($rose(secreg_lock_bit));
endmodule : srp_secreg_checker

bind srp_secreg srp_secreg_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .secreg_lock_set(secreg_lock_set), .secreg_lock_bit(secreg_lock_bit),
    .write_latch_flag(write_latch_flag), .cycle_active_flag(cycle_active_flag));

// ==== sim/srp_host_model.sv ====
`timescale 1ns/1ps
module srp_host_model (
    // serial link
    output logic       sclk,
    output logic       cs_n,
    output logic       si,
    input  wire logic  so,
    input  wire logic  so_oe,
    // received bytes
    output logic [7:0] rx_byte,
    output logic       rx_stb
);
    logic [7:0] txq[$];
    logic       smp;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx_byte = 8'h00;
        rx_stb = 1'b0;
    end
    // an undriven so reads as unknown so a missing enable never passes
    task automatic bit_cyc(input logic v);
        si = v;
        #6 sclk = 1'b1;
        smp = so_oe ? so : 1'bx;
        #6 sclk = 1'b0;
    endtask : bit_cyc
    // sclk rests low between frames; si shows its inverse once released
    task automatic run(input int nrx);
        logic [7:0] b;
        cs_n = 1'b0;
        while (txq.size() > 0) begin
            b = txq.pop_front();
            for (int i = 7; i >= 0; i--) bit_cyc(b[i]);
        end
        for (int n = 0; n < nrx; n++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_cyc(~si);
                b[i] = smp;
            end
            rx_byte = b;
            rx_stb = 1'b1;
            #1 rx_stb = 1'b0;
        end
        #5 cs_n = 1'b1;
        si = ~si;
        #80;
    endtask : run
endmodule : srp_host_model

// ==== sim/test_security_register_program_read.sv ====
`timescale 1ns/1ps
module test_security_register_program_read;
    localparam int unsigned PCYC = 400;
    logic       ref_clk, rst_n, sclk, cs_n, si, so, so_oe, rx_stb;
    logic       secreg_lock_set, secreg_lock_bit, write_latch_flag, cycle_active_flag;
    logic [7:0] rx_byte;
    logic [7:0] expq[$];
    logic [7:0] mem[0:1023];
    int         error_cnt = 0;
    int         n_tests = 0;
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    srp_host_model u_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
        .rx_byte(rx_byte), .rx_stb(rx_stb));
    srp_secreg #(.PROG_CYCLES(PCYC)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .si(si), .so(so), .so_oe(so_oe), .secreg_lock_set(secreg_lock_set), .secreg_lock_bit(secreg_lock_bit),
        .write_latch_flag(write_latch_flag), .cycle_active_flag(cycle_active_flag));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic flags(input logic [2:0] e);
        @(posedge ref_clk);
        #1;
        chk("lock latch busy", {5'h00, e}, {5'h00, secreg_lock_bit, write_latch_flag, cycle_active_flag});
    endtask : flags
    // ok marks a program the bench expects to land; cells only clear bits
    task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int nd, input int nrx, input bit ok);
        logic [7:0] d;
        @(posedge ref_clk);
        #1;
        u_host.txq.push_back(op);
        if (op != srp_pkg::OP_WRITE_PERMIT) for (int i = 2; i >= 0; i--) u_host.txq.push_back(adr[i*8 +: 8]);
        for (int i = 0; i < nd; i++) begin
            d = 8'($urandom);
            u_host.txq.push_back(d);
            if (ok) mem[{adr[9:8], 8'(adr[7:0] + i)}] &= d;
        end
        if (nrx > 0) u_host.txq.push_back(8'($urandom));
        for (int i = 0; i < nrx; i++) expq.push_back(mem[10'(adr[9:0] + i)]);
        u_host.run(nrx);
    endtask : frame
    task automatic wait_idle();
        int n = 0;
        while (cycle_active_flag !== 1'b0) begin
            @(posedge ref_clk);
            n++;
            if (n > PCYC + 50) begin
                error_cnt++;
                complete_run();
            end
        end
    endtask : wait_idle
    initial forever begin
        @(posedge rx_stb);
        chk("read byte queued", 8'h01, 8'(expq.size() > 0));
        if (expq.size() > 0) chk("read byte", expq.pop_front(), rx_byte);
    end
    initial begin
        rst_n = 1'b0;
        secreg_lock_set = 1'b0;
        for (int i = 0; i < 1024; i++) mem[i] = srp_pkg::ERASED_BYTE;
        void'($urandom(79426));
        repeat (16) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (20) @(posedge ref_clk);
        flags(3'b000);
        frame(srp_pkg::OP_SECREG_READ, 24'h0001FE, 0, 4, 0);
        frame(srp_pkg::OP_SECREG_PROG, 24'h000010, 1, 0, 0);
        flags(3'b000);
        frame(srp_pkg::OP_WRITE_PERMIT, 24'h000000, 0, 0, 0);
        flags(3'b010);
        frame(srp_pkg::OP_SECREG_PROG, 24'h010000, 1, 0, 0);
        frame(srp_pkg::OP_SECREG_PROG, 24'h000400, 1, 0, 0);
        flags(3'b010);
        frame(srp_pkg::OP_SECREG_PROG, 24'h0003FE, 3, 0, 1);
        flags(3'b011);
        wait_idle();
        flags(3'b000);
        frame(srp_pkg::OP_SECREG_READ, 24'h0003FE, 0, 4, 0);
        frame(srp_pkg::OP_SECREG_READ, 24'h0002FF, 0, 2, 0);
        frame(srp_pkg::OP_WRITE_PERMIT, 24'h000000, 0, 0, 0);
        frame(srp_pkg::OP_SECREG_PROG, 24'h000100, 256, 0, 1);
        flags(3'b011);
        wait_idle();
        frame(srp_pkg::OP_SECREG_READ, 24'h000100, 0, 256, 0);
        @(posedge ref_clk);
        #1 secreg_lock_set = 1'b1;
        @(posedge ref_clk);
        #1 secreg_lock_set = 1'b0;
        flags(3'b100);
        frame(srp_pkg::OP_WRITE_PERMIT, 24'h000000, 0, 0, 0);
        frame(srp_pkg::OP_SECREG_PROG, 24'h000200, 1, 0, 0);
        flags(3'b110);
        frame(srp_pkg::OP_SECREG_READ, 24'h000200, 0, 1, 0);
        repeat (10) @(posedge ref_clk);
        chk("pending reads", 8'h00, 8'(expq.size()));
        complete_run();
    end
endmodule : test_security_register_program_read
